// ---- cphp_copro_model.sv ----
module cphp_copro_model
    import cphp_pkg::*;
#(
    parameter logic UNIT = 1'b0
)
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        coproc_request_n_out,
    input  wire logic        instr_valid_n_out,
    input  wire logic        condition_pass_out,
    input  wire logic [31:0] instruction_bus_out,
    input  wire logic [7:0]  waits,
    input  wire logic [3:0]  burst,
    output logic      [1:0]  decode_handshake_in,
    output logic      [1:0]  execute_handshake_in,
    output logic      [3:0]  burst_word_count_in,
    output logic      [31:0] coproc_read_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Coprocessor
    // ----
    logic       exec_r;
    logic       first_r;
    logic [7:0] cnt_r;
    // Only the unit whose number matches instruction bit 8 answers; the other stays absent
    wire        dec = !coproc_request_n_out && !exec_r && instruction_bus_out[8] == UNIT;
    // Absent whenever idle so a second unit could share the wires
    assign decode_handshake_in = (!dec || instr_valid_n_out) ? CPHP_HS_ABSENT
        : (waits > 8'h01 ? CPHP_HS_WAIT
        : (waits == 8'h01 ? CPHP_HS_GO : CPHP_HS_LAST));
    assign execute_handshake_in = !exec_r ? CPHP_HS_ABSENT
        : (cnt_r != 8'h00 ? CPHP_HS_WAIT : CPHP_HS_LAST);
    assign burst_word_count_in = (dec && !instr_valid_n_out) ? burst : 4'h0;
    assign coproc_read_data_in = (exec_r && cnt_r == 8'h00) ? ~instruction_bus_out
        : 32'h0000_0000;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            exec_r  <= 1'b0;
            first_r <= 1'b0;
            cnt_r   <= 8'h00;
        end else if (dec) begin
            exec_r  <= decode_handshake_in == CPHP_HS_WAIT || decode_handshake_in == CPHP_HS_GO;
            first_r <= 1'b1;
            cnt_r   <= waits - 8'h01;
        end else if (exec_r) begin
            first_r <= 1'b0;
            cnt_r   <= cnt_r - 8'h01;
            if (cnt_r == 8'h00 || !condition_pass_out || (first_r && coproc_request_n_out))
                exec_r <= 1'b0;
        end
    end
endmodule

// ---- cphp_pkg.sv ----
package cphp_pkg;

    // ------------------------------------------------------------
    // Handshake codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CPHP_HS_WAIT   = 2'h0,
        CPHP_HS_GO     = 2'h1,
        CPHP_HS_ABSENT = 2'h2,
        CPHP_HS_LAST   = 2'h3
    } cphp_hs_t;

    // ------------------------------------------------------------
    // Widths and fixed values
    // ------------------------------------------------------------
    localparam int          CPHP_INSTR_W   = 32;
    localparam int          CPHP_DATA_W    = 32;
    localparam int          CPHP_BURST_W   = 4;
    localparam logic [3:0]  CPHP_BURST_ONE = 4'h0;
    localparam logic [4:0]  CPHP_WORDS_ONE = 5'h01;

endpackage

// ---- cphp_port.sv ----
// What this block does
// [RQ1] A coprocessor that must stall answers wait on the decode handshake while its instruction is in Decode.
// [RQ2] In Execute the coprocessor may hold wait for any number of cycles and the processor holds the instruction that long.
// [RQ3] The coprocessor samples condition pass each busy-wait cycle, executing when high and abandoning when low.
// [RQ4] An interrupt that forces a busy-waiting instruction out drives condition pass low and raises late cancel.
// [RQ5] The burst count code 0 means one word or unknown and code N means N+1 words.
// [RQ6] The memory side uses the burst count to issue noncached or nonbuffered coprocessor load/store as one burst.
// [RQ7] A zero burst count makes every resulting bus transfer an individual nonsequential access.
// [RQ8] The coprocessor drives the burst count only with its decode handshake answer and zero otherwise.
// [RQ9] The load/store abort output rises in the cycle after the Memory stage of an aborted coprocessor load/store.
// [RQ10] While instruction valid (active low) is 1 the coprocessor ignores the instruction and answers absent.
// [RQ11] Several coprocessors combine by ANDing the handshake upper bits and ORing the lower bits.
// [RQ12] An inactive coprocessor outputs the absent code on its handshake outputs.
// [RQ13] Read data and burst counts are ORed, so a coprocessor not owning the stage drives zeros.
// [RQ14] Handshake codes are 00 wait, 01 go, 10 absent, 11 last, and absent takes the undefined trap.
// [RQ15] The instruction commits when last is seen on execute handshake with condition pass high.
// [RQ16] The request (active low) goes low as an instruction enters Decode and again when it issues to Execute.
module cphp_port
    import cphp_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // Pipeline side
    input  wire logic                    pipe_decode_valid_in,
    input  wire logic [CPHP_INSTR_W-1:0] pipe_instr_in,
    input  wire logic                    pipe_instr_thumb_in,
    input  wire logic                    pipe_cond_ok_in,
    input  wire logic                    pipe_irq_in,
    input  wire logic                    pipe_is_ldst_in,
    input  wire logic                    pipe_mem_uncached_in,
    input  wire logic                    pipe_mem_abort_in,
    output logic                         pipe_stall_out,
    output logic                         pipe_undef_out,
    output logic                         pipe_commit_out,
    output logic                         pipe_abandon_out,
    output logic [CPHP_DATA_W-1:0]       pipe_read_data_out,
    // Memory side
    output logic                         mem_burst_req_out,
    output logic [4:0]                   mem_burst_words_out,
    output logic                         mem_single_nonseq_out,
    // Coprocessor bus
    output logic [CPHP_INSTR_W-1:0]      instruction_bus_out,
    output logic                         instr_valid_n_out,
    output logic                         coproc_request_n_out,
    output logic                         condition_pass_out,
    output logic                         late_cancel_out,
    output logic                         load_store_abort_out,
    input  wire logic [1:0]              decode_handshake_in,
    input  wire logic [1:0]              execute_handshake_in,
    input  wire logic [CPHP_BURST_W-1:0] burst_word_count_in,
    input  wire logic [CPHP_DATA_W-1:0]  coproc_read_data_in
);

    // ------------------------------------------------------------
    // Pipeline state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CPHP_IDLE, CPHP_DECODE, CPHP_EXEC} cphp_state_t;

    cphp_state_t           state_r;
    cphp_state_t           state_nxt;
    logic                  ldst_r;
    logic                  uncached_r;
    logic [3:0]            burst_r;
    logic                  mem_stage_r;
    cphp_hs_t              de_hs;
    cphp_hs_t              ex_hs;

    // ------------------------------------------------------------
    // Combined coprocessor answers
    // ------------------------------------------------------------
    // Combined bus answers from all coprocessors arrive already wired [RQ11] [RQ12] [RQ13]
    assign de_hs = cphp_hs_t'(decode_handshake_in);
    assign ex_hs = cphp_hs_t'(execute_handshake_in);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CPHP_IDLE: begin
                if (pipe_decode_valid_in) begin
                    state_nxt = CPHP_DECODE;
                end
            end
            CPHP_DECODE: begin
                if (!pipe_cond_ok_in || de_hs == CPHP_HS_ABSENT) begin // [RQ14]
                    state_nxt = CPHP_IDLE;
                end else if (de_hs == CPHP_HS_LAST) begin
                    state_nxt = CPHP_IDLE;
                end else begin
                    state_nxt = CPHP_EXEC; // [RQ1]
                end
            end
            CPHP_EXEC: begin
                // Busy-wait loop lasts as long as the coprocessor says wait [RQ2]
                if (pipe_irq_in && ex_hs == CPHP_HS_WAIT) begin
                    state_nxt = CPHP_IDLE; // [RQ4]
                end else if (ex_hs == CPHP_HS_LAST || ex_hs == CPHP_HS_ABSENT) begin
                    state_nxt = CPHP_IDLE; // [RQ15]
                end
            end
            default: state_nxt = CPHP_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= CPHP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Coprocessor bus drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            instruction_bus_out  <= '0;
            instr_valid_n_out    <= 1'b1;
            coproc_request_n_out <= 1'b1;
        end else begin
            // Low once for Decode entry, once for issue to Execute [RQ16]
            coproc_request_n_out <= !((state_nxt == CPHP_DECODE && state_r == CPHP_IDLE)
                                     || (state_nxt == CPHP_EXEC && state_r == CPHP_DECODE));
            if (state_r == CPHP_IDLE && pipe_decode_valid_in) begin
                instruction_bus_out <= pipe_instr_in;
                instr_valid_n_out   <= pipe_instr_thumb_in; // [RQ10]
            end
        end
    end

    // ------------------------------------------------------------
    // Condition pass and late cancel
    // ------------------------------------------------------------
    // Condition pass falls with the interrupt so the coprocessor abandons [RQ3] [RQ4]
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            condition_pass_out <= 1'b0;
            late_cancel_out    <= 1'b0;
            pipe_abandon_out   <= 1'b0;
        end else begin
            condition_pass_out <= (state_nxt == CPHP_EXEC) && pipe_cond_ok_in && !pipe_irq_in;
            late_cancel_out    <= (state_r == CPHP_EXEC) && pipe_irq_in
                                  && ex_hs == CPHP_HS_WAIT; // [RQ4]
            pipe_abandon_out   <= (state_r == CPHP_EXEC) && pipe_irq_in
                                  && ex_hs == CPHP_HS_WAIT;
        end
    end

    // ------------------------------------------------------------
    // Pipeline status
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pipe_stall_out     <= 1'b0;
            pipe_undef_out     <= 1'b0;
            pipe_commit_out    <= 1'b0;
            pipe_read_data_out <= '0;
        end else begin
            pipe_stall_out  <= state_nxt == CPHP_EXEC && ex_hs == CPHP_HS_WAIT; // [RQ2]
            pipe_undef_out  <= (state_r == CPHP_DECODE && pipe_cond_ok_in
                                && de_hs == CPHP_HS_ABSENT)
                               || (state_r == CPHP_EXEC && ex_hs == CPHP_HS_ABSENT); // [RQ14]
            pipe_commit_out <= (state_r == CPHP_EXEC && ex_hs == CPHP_HS_LAST
                                && condition_pass_out)
                               || (state_r == CPHP_DECODE && de_hs == CPHP_HS_LAST
                                   && pipe_cond_ok_in); // [RQ15]
            pipe_read_data_out <= coproc_read_data_in; // [RQ13]
        end
    end

    // ------------------------------------------------------------
    // Burst handling and memory requests
    // ------------------------------------------------------------
    // Burst count is only meaningful alongside the decode answer [RQ8]
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ldst_r     <= 1'b0;
            uncached_r <= 1'b0;
            burst_r    <= CPHP_BURST_ONE;
        end else if (state_r == CPHP_DECODE) begin
            ldst_r     <= pipe_is_ldst_in;
            uncached_r <= pipe_mem_uncached_in;
            burst_r    <= burst_word_count_in; // [RQ8]
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mem_burst_req_out     <= 1'b0;
            mem_burst_words_out   <= CPHP_WORDS_ONE;
            mem_single_nonseq_out <= 1'b0;
        end else begin
            mem_burst_req_out     <= pipe_commit_out && ldst_r && uncached_r
                                     && burst_r != CPHP_BURST_ONE; // [RQ6]
            mem_burst_words_out   <= {1'b0, burst_r} + CPHP_WORDS_ONE; // [RQ5]
            mem_single_nonseq_out <= pipe_commit_out && ldst_r && uncached_r
                                     && burst_r == CPHP_BURST_ONE; // [RQ7]
        end
    end

    // ------------------------------------------------------------
    // Memory stage and abort
    // ------------------------------------------------------------
    // Memory stage follows commit; abort shows one cycle after it
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mem_stage_r <= 1'b0;
        end else begin
            mem_stage_r <= pipe_commit_out && ldst_r;
        end
    end

    // Abort input is only trusted in the memory stage, so a stray level elsewhere is ignored
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            load_store_abort_out <= 1'b0;
        end else begin
            load_store_abort_out <= mem_stage_r && pipe_mem_abort_in; // [RQ9]
        end
    end

endmodule

// ---- cphp_port_chk.sv ----
module cphp_port_chk
    import cphp_pkg::*;
(
    input wire logic                    clk_in,
    input wire logic                    reset_in,
    input wire logic                    pipe_irq_in,
    input wire logic                    pipe_is_ldst_in,
    input wire logic                    pipe_mem_uncached_in,
    input wire logic                    pipe_mem_abort_in,
    input wire logic                    pipe_stall_out,
    input wire logic                    pipe_undef_out,
    input wire logic                    pipe_commit_out,
    input wire logic                    pipe_abandon_out,
    input wire logic                    mem_burst_req_out,
    input wire logic [4:0]              mem_burst_words_out,
    input wire logic                    mem_single_nonseq_out,
    input wire logic                    coproc_request_n_out,
    input wire logic                    condition_pass_out,
    input wire logic                    late_cancel_out,
    input wire logic                    load_store_abort_out,
    input wire logic [1:0]              decode_handshake_in,
    input wire logic [1:0]              execute_handshake_in,
    input wire logic [CPHP_BURST_W-1:0] burst_word_count_in,
    input wire logic [CPHP_INSTR_W-1:0] pipe_instr_in,
    input wire logic                    pipe_instr_thumb_in,
    input wire logic                    pipe_cond_ok_in,
    input wire logic [CPHP_INSTR_W-1:0] instruction_bus_out,
    input wire logic                    instr_valid_n_out,
    input wire logic [CPHP_DATA_W-1:0]  pipe_read_data_out,
    input wire logic [CPHP_DATA_W-1:0]  coproc_read_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Checks
    // ----
    // Burst code seen with the decode answer; the far side zeroes it elsewhere
    logic [3:0] cap_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            cap_r <= 4'h0;
        else if (!coproc_request_n_out && decode_handshake_in != CPHP_HS_ABSENT)
            cap_r <= burst_word_count_in;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    a_busy_wait_hold: assert property (
        pipe_stall_out && execute_handshake_in == CPHP_HS_WAIT && !pipe_irq_in |=> pipe_stall_out)
        else $error("stall dropped while wait");
    a_irq_cancel: assert property (
        pipe_stall_out && condition_pass_out && execute_handshake_in == CPHP_HS_WAIT && pipe_irq_in
        |=> late_cancel_out && pipe_abandon_out && !condition_pass_out)
        else $error("no late cancel on irq");
    a_commit_last: assert property (
        condition_pass_out && pipe_stall_out && execute_handshake_in == CPHP_HS_LAST
        |=> pipe_commit_out && !late_cancel_out)
        else $error("no commit on last");
    a_burst_words: assert property (
        mem_burst_req_out |-> cap_r != 4'h0 && mem_burst_words_out == {1'b0, cap_r} + 5'h01)
        else $error("bad burst words");
    a_single_nonseq: assert property (
        mem_single_nonseq_out |-> cap_r == 4'h0 && !mem_burst_req_out)
        else $error("single access with burst code");
    a_mem_after_commit: assert property (
        pipe_commit_out && pipe_is_ldst_in && pipe_mem_uncached_in
        |=> mem_burst_req_out || mem_single_nonseq_out)
        else $error("no memory request after commit");
    a_abort_timing: assert property (
        pipe_commit_out && pipe_is_ldst_in ##1 pipe_mem_abort_in |=> load_store_abort_out)
        else $error("abort output late");
    a_undef_absent: assert property (
        pipe_undef_out |-> $past(decode_handshake_in) == CPHP_HS_ABSENT
        && !$past(coproc_request_n_out))
        else $error("undef without absent");
    a_decode_entry: assert property (
        $fell(coproc_request_n_out) |-> instruction_bus_out == $past(pipe_instr_in)
        && instr_valid_n_out == $past(pipe_instr_thumb_in))
        else $error("decode request without its instruction");
    a_issue_request: assert property (
        $fell(coproc_request_n_out) && pipe_cond_ok_in && !pipe_irq_in
        && (decode_handshake_in == CPHP_HS_WAIT || decode_handshake_in == CPHP_HS_GO)
        |=> !coproc_request_n_out && condition_pass_out)
        else $error("no issue request to execute");
    a_read_data_path: assert property (
        pipe_read_data_out == $past(coproc_read_data_in))
        else $error("read data not passed on");
endmodule

bind cphp_port cphp_port_chk u_cphp_port_chk (.*);

// ---- cphp_port_tb.sv ----
module cphp_port_tb
    import cphp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_in = 1'b1, pipe_decode_valid_in = 1'b0, pipe_instr_thumb_in = 1'b0;
    logic pipe_cond_ok_in = 1'b0, pipe_irq_in = 1'b0, pipe_is_ldst_in = 1'b0;
    logic pipe_mem_uncached_in = 1'b0, pipe_mem_abort_in = 1'b0;
    logic [31:0] pipe_instr_in = 32'h0000_0000, pipe_read_data_out, instruction_bus_out;
    logic [31:0] coproc_read_data_in, rnd;
    logic [31:0] rd_a, rd_b;
    logic [1:0] dh_a, dh_b, eh_a, eh_b;
    logic [3:0] bw_a, bw_b;
    logic pipe_stall_out, pipe_undef_out, pipe_commit_out, pipe_abandon_out, mem_burst_req_out;
    logic mem_single_nonseq_out, instr_valid_n_out, coproc_request_n_out, condition_pass_out;
    logic late_cancel_out, load_store_abort_out;
    logic [4:0] mem_burst_words_out;
    logic [1:0] decode_handshake_in, execute_handshake_in;
    logic [3:0] burst_word_count_in, burst = 4'h0;
    logic [7:0] waits = 8'h00, exp_q[$];
    int errors = 0, checks_done = 0, seed = 32'h0000_042e;
    cphp_port u_cphp_port (.*);
    cphp_copro_model #(.UNIT(1'b0)) u_cphp_copro_model_a (.*, .decode_handshake_in(dh_a),
        .execute_handshake_in(eh_a), .burst_word_count_in(bw_a), .coproc_read_data_in(rd_a));
    cphp_copro_model #(.UNIT(1'b1)) u_cphp_copro_model_b (.*, .decode_handshake_in(dh_b),
        .execute_handshake_in(eh_b), .burst_word_count_in(bw_b), .coproc_read_data_in(rd_b));
    // Two units share the processor inputs through the wired combination
    assign decode_handshake_in = {dh_a[1] & dh_b[1], dh_a[0] | dh_b[0]};
    assign execute_handshake_in = {eh_a[1] & eh_b[1], eh_a[0] | eh_b[0]};
    assign burst_word_count_in = bw_a | bw_b;
    assign coproc_read_data_in = rd_a | rd_b;
    always #2 clk_in = ~clk_in;
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic compare(input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // ----
    // Monitor: each result takes the oldest note
    // ----
    task automatic see(input logic [7:0] got);
        compare(exp_q.size() > 0 ? exp_q.pop_front() : 8'hff, got);
    endtask
    always @(negedge clk_in) if (!reset_in) begin
        if (pipe_commit_out === 1'b1) see(8'h20);
        if (pipe_undef_out === 1'b1) see(8'h40);
        if (late_cancel_out === 1'b1) see({7'h30, pipe_abandon_out});
        if (mem_burst_req_out === 1'b1) see({3'h4, mem_burst_words_out});
        if (mem_single_nonseq_out === 1'b1) see(8'ha0);
        if (load_store_abort_out === 1'b1) see(8'hc0);
    end
    // Flags are {thumb, cond, irq, ldst, uncached, abort}; irq lands mid busy-wait
    task automatic run(input logic [5:0] f, input logic [7:0] w, input logic [3:0] b);
        logic go;
        go = !f[5] && f[4] && !f[3];
        if (f[5] && f[4]) exp_q.push_back(8'h40);
        if (!f[5] && f[4] && f[3]) exp_q.push_back(8'h61);
        if (go) exp_q.push_back(8'h20);
        if (go && f[2] && f[1]) exp_q.push_back(b == 4'h0 ? 8'ha0 : {4'h8, b} + 8'h01);
        if (go && f[2] && f[1] && f[0]) exp_q.push_back(8'hc0);
        {pipe_instr_thumb_in, pipe_cond_ok_in} <= f[5:4];
        {pipe_is_ldst_in, pipe_mem_uncached_in, pipe_mem_abort_in} <= f[2:0];
        waits <= w;
        burst <= b;
        pipe_instr_in <= $random(seed);
        pipe_decode_valid_in <= 1'b1;
        @(posedge clk_in);
        pipe_decode_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        pipe_irq_in <= f[3];
        repeat (int'(w) + 12) @(posedge clk_in);
        pipe_irq_in <= 1'b0;
        $display("test done, %0d notes left", exp_q.size());
    endtask
    initial begin
        #20000;
        errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        run(6'b010000, 8'h00, 4'h0);
        run(6'b010000, 8'h03, 4'h0);
        run(6'b110000, 8'h02, 4'h0);
        run(6'b000000, 8'h02, 4'h0);
        run(6'b011000, 8'h06, 4'h0);
        run(6'b010110, 8'h01, 4'h0);
        run(6'b010110, 8'h02, 4'hf);
        run(6'b010111, 8'h02, 4'h1);
        repeat (8) begin
            rnd = $random(seed);
            run({3'b010, rnd[1:0], 1'b0}, {5'h00, rnd[4:2]}, rnd[11:8]);
        end
        compare(8'h00, 8'(exp_q.size()));
        final_report();
    end
endmodule
